// ### verilog/lsm_pkg.sv
// constants, register map and carrier types of the led string monitor
// assumes a 50 MHz reference clock and a register file port behind the serial interface
package lsm_pkg;
  // ****************************************
  // clocking and timing
  // ****************************************
  localparam int REF_CLK_HZ = 50_000_000;
  localparam int ADC_CLK_HZ = 1_000_000;
  localparam int TICK_DIV = REF_CLK_HZ / ADC_CLK_HZ;
  localparam int WINDOW_MS = 190;
  localparam int WINDOW_TICKS = WINDOW_MS * (ADC_CLK_HZ / 1000);
  localparam int ONTIME_US = 10;
  localparam int ONTIME_TICKS = ONTIME_US * (ADC_CLK_HZ / 1_000_000);
  localparam int SAR_BITS = 7;
  localparam logic [3:0] SAMPLE_TICKS = 4'(ONTIME_TICKS - SAR_BITS);
  localparam int NUM_STR = 4;
  localparam int NUM_CH = 5;
  localparam logic [2:0] CH_VOUT = 3'h4;
  localparam logic [2:0] CH_FIRST = 3'h0;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_RES_BASE = 8'h00;
  localparam logic [7:0] ADDR_IREF_BASE = 8'h05;
  localparam logic [7:0] ADDR_VADJ = 8'h09;
  localparam logic [7:0] ADDR_FAULT = 8'h0a;
  localparam logic [7:0] ADDR_STANDBY = 8'h0b;
  localparam logic [7:0] RES_RST = 8'h00;
  localparam logic [6:0] IREF_RST = 7'h00;
  localparam logic [6:0] VADJ_RST = 7'h00;
  localparam logic [7:0] RES_FULL = 8'h7f;
  localparam int RES_TMO_BIT = 7;
  localparam int FLT_OV_BIT = 4;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic enable;
    logic supply_undervoltage_lockout;
    logic hot;
    logic output_overvoltage_sense;
    logic comp;
    logic [NUM_STR-1:0] short_trip;
    logic [NUM_STR-1:0] dim;
  } lsm_pins_t;

  typedef struct packed {
    logic [6:0] iref3;
    logic [6:0] iref2;
    logic [6:0] iref1;
    logic [6:0] iref0;
  } lsm_iref_t;
endpackage

// ### verilog/lsm_sync.sv
// two-stage synchroniser for a bundle of asynchronous pin levels
// assumes every bit is an independent level from outside the clock domain
`timescale 1ns/1ps
module lsm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ****************************************
  // two flops per bit
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign q = sync_q;
endmodule

// ### verilog/lsm_sar.sv
// seven-bit successive-approximation sequencer, advanced by gated 1 MHz ticks
// assumes an external comparator reporting input at or above the presented trial code
`timescale 1ns/1ps
module lsm_sar (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic gate,
  input wire logic start,
  input wire logic abort,
  input wire logic comp,
  output logic busy,
  output logic done,
  output logic [6:0] trial
);
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [3:0] smp_q, smp_d;
  logic [2:0] idx_q, idx_d;
  logic [6:0] code_q, code_d;
  wire step = busy_q & tick & gate;
  wire sampling = (smp_q != lsm_pkg::SAMPLE_TICKS);
  wire [6:0] bitmask = 7'h01 << idx_q;

  // ****************************************
  // sequencing
  // ****************************************
  // sample phase then one decision per on-phase tick, msb first
  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    smp_d = smp_q;
    idx_d = idx_q;
    code_d = code_q;
    if (abort) begin
      busy_d = 1'b0;
    end else if (!busy_q && start) begin
      busy_d = 1'b1;
      smp_d = 4'h0;
      idx_d = 3'(lsm_pkg::SAR_BITS - 1);
      code_d = 7'h00;
    end else if (step && sampling) begin
      smp_d = smp_q + 4'h1;
    end else if (step) begin
      code_d = comp ? (code_q | bitmask) : code_q;
      if (idx_q == 3'h0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        idx_d = idx_q - 3'h1;
      end
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      smp_q <= 4'h0;
      idx_q <= 3'h0;
      code_q <= 7'h00;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      smp_q <= smp_d;
      idx_q <= idx_d;
      code_q <= code_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign trial = (busy_q && !sampling) ? (code_q | bitmask) : code_q; // final code once done
endmodule

// ### verilog/lsm_top.sv
// digital control of a four-string led driver: protection, sink gating,
// current references and the five-channel drain/output measurement sequencer
// assumes a register file port behind the serial interface and analog
// comparators on the pins; status and comparator pins are asynchronous to REF_CLK, the register port is not
`timescale 1ns/1ps
module lsm_top #(
  parameter int WINDOW_TICKS = lsm_pkg::WINDOW_TICKS
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SYNC_ENABLE,
  input wire logic SUPPLY_UNDERVOLTAGE_LOCKOUT,
  input wire logic DIE_HOT,
  input wire logic OUTPUT_OVERVOLTAGE_SENSE,
  input wire logic ADC_COMP,
  input wire logic [3:0] DRAIN_SHORT_TRIP,
  input wire logic [3:0] STRING_DIM_INPUTS,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REGULATOR_GATE_EN,
  output logic SOFT_START_DISCHARGE,
  output logic [3:0] SINK_GATE_DRIVES,
  output lsm_pkg::lsm_iref_t IREF_CODES,
  output logic [6:0] VOUT_ADJ,
  output logic [2:0] ADC_MUX_SEL,
  output logic [6:0] ADC_TRIAL_CODE
);
  typedef enum logic [2:0] {
    ST_CONV = 3'b001,
    ST_ADV = 3'b010,
    ST_HALT = 3'b100
  } lsm_state_t;

  // ****************************************
  // pin synchronisation
  // ****************************************
  lsm_pkg::lsm_pins_t pins_raw;
  lsm_pkg::lsm_pins_t pins;
  assign pins_raw = '{
    enable: SYNC_ENABLE,
    supply_undervoltage_lockout: SUPPLY_UNDERVOLTAGE_LOCKOUT,
    hot: DIE_HOT,
    output_overvoltage_sense: OUTPUT_OVERVOLTAGE_SENSE,
    comp: ADC_COMP,
    short_trip: DRAIN_SHORT_TRIP,
    dim: STRING_DIM_INPUTS
  };
  lsm_sync #(.W($bits(lsm_pkg::lsm_pins_t))) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d(pins_raw),
    .q(pins)
  );

  // ****************************************
  // register write decode
  // ****************************************
  logic [6:0] iref_q [lsm_pkg::NUM_STR];
  logic [6:0] vadj_q;
  logic standby_q;
  logic en_prev_q;
  wire wr_vadj = REG_WR && (REG_ADDR == lsm_pkg::ADDR_VADJ);
  wire wr_standby_state = REG_WR && (REG_ADDR == lsm_pkg::ADDR_STANDBY);
  wire standby_rise = wr_standby_state && REG_WDATA[0] && !standby_q;
  wire en_toggle = pins.enable ^ en_prev_q;
  wire en_fall = en_prev_q && !pins.enable;
  wire clr_faults = en_fall;

  // true when addr selects slot n of a block starting at base
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base, input int n);
    hit = (addr == base + 8'(n));
  endfunction

  // write-only-by-software registers; code 0 is the 316mV top, each count one step down
  genvar s;
  generate
    for (s = 0; s < lsm_pkg::NUM_STR; s++) begin : g_iref
      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          iref_q[s] <= lsm_pkg::IREF_RST;
        end else if (REG_WR && hit(REG_ADDR, lsm_pkg::ADDR_IREF_BASE, s)) begin
          iref_q[s] <= REG_WDATA[6:0];
        end
      end
    end
  endgenerate

  // output adjust, standby and enable history
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      vadj_q <= lsm_pkg::VADJ_RST;
      standby_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      if (wr_vadj) vadj_q <= REG_WDATA[6:0];
      if (wr_standby_state) standby_q <= REG_WDATA[0];
      en_prev_q <= pins.enable;
    end
  end

  // ****************************************
  // protection
  // ****************************************
  logic ov_latch_q;
  logic ov_seen_q;
  logic [3:0] short_q;
  wire ov_clear = en_toggle || standby_rise;
  wire shutdown = !pins.enable;
  wire halt = shutdown || pins.supply_undervoltage_lockout || standby_q || pins.hot;
  wire [3:0] short_new = pins.short_trip & ~short_q;

  // overvoltage latch, sets win over clears
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ov_latch_q <= 1'b0;
    end else if (pins.output_overvoltage_sense) begin
      ov_latch_q <= 1'b1;
    end else if (ov_clear) begin
      ov_latch_q <= 1'b0;
    end
  end

  // fault record: shorted strings and overvoltage events
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      short_q <= 4'h0;
      ov_seen_q <= 1'b0;
    end else begin
      short_q <= (clr_faults ? 4'h0 : short_q) | (pins.enable ? pins.short_trip : 4'h0);
      ov_seen_q <= (ov_seen_q && !clr_faults) || pins.output_overvoltage_sense;
    end
  end

  // drive outputs; each sink follows its dim input when allowed
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REGULATOR_GATE_EN <= 1'b0;
      SOFT_START_DISCHARGE <= 1'b1;
      SINK_GATE_DRIVES <= 4'h0;
    end else begin
      REGULATOR_GATE_EN <= !halt && !ov_latch_q && !pins.output_overvoltage_sense;
      SOFT_START_DISCHARGE <= halt || ov_latch_q || pins.output_overvoltage_sense;
      SINK_GATE_DRIVES <= halt ? 4'h0 : (pins.dim & ~short_q & ~pins.short_trip);
    end
  end

  // ****************************************
  // measurement sequencer
  // ****************************************
  logic [5:0] div_q;
  logic tick_q;
  logic [17:0] win_q;
  logic [2:0] ch_q, ch_d;
  lsm_state_t st_q, st_d;
  logic sar_busy, sar_done;
  logic [6:0] sar_trial;
  wire [4:0] ch_lock = {1'b0, short_q};
  wire ch_gate = (ch_q == lsm_pkg::CH_VOUT) ? |pins.dim : pins.dim[ch_q[1:0]];
  wire win_end = tick_q && (win_q == 18'(WINDOW_TICKS - 1));
  wire short_here = ch_lock[ch_q] || ((ch_q != lsm_pkg::CH_VOUT) && pins.short_trip[ch_q[1:0]]);
  wire sar_abort = halt || short_here || win_end;
  wire sar_start = (st_q == ST_CONV) && !sar_busy && !sar_abort;

  // next channel in ascending order, skipping locked ones
  function automatic logic [2:0] next_ch(input logic [2:0] cur, input logic [4:0] lock);
    logic [2:0] c;
    logic found;
    c = cur;
    found = 1'b0;
    next_ch = cur;
    for (int k = 0; k < lsm_pkg::NUM_CH; k++) begin
      c = (c == lsm_pkg::CH_VOUT) ? lsm_pkg::CH_FIRST : c + 3'h1;
      if (!found && !lock[c]) begin
        next_ch = c;
        found = 1'b1;
      end
    end
  endfunction

  // 1 MHz conversion tick from the reference clock
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      div_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      div_q <= (div_q == 6'(lsm_pkg::TICK_DIV - 1)) ? 6'h00 : div_q + 6'h01;
      tick_q <= (div_q == 6'(lsm_pkg::TICK_DIV - 1));
    end
  end

  // selector state machine
  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    case (st_q)
      ST_CONV: begin
        if (halt) st_d = ST_HALT;
        else if (sar_done || win_end || short_here) st_d = ST_ADV;
      end
      ST_ADV: begin
        ch_d = next_ch(ch_q, ch_lock);
        st_d = halt ? ST_HALT : ST_CONV;
      end
      ST_HALT: begin
        if (shutdown) ch_d = lsm_pkg::CH_FIRST;
        if (!halt) st_d = ST_CONV;
      end
      default: st_d = ST_HALT;
    endcase
  end

  // selector registers and per-channel window timer
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q <= ST_HALT;
      ch_q <= lsm_pkg::CH_FIRST;
      win_q <= 18'h00000;
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
      if (st_q != ST_CONV) win_q <= 18'h00000;
      else if (tick_q) win_q <= win_q + 18'h00001;
    end
  end

  lsm_sar u_sar (
    .clk(REF_CLK),
    .rst(RST),
    .tick(tick_q),
    .gate(ch_gate),
    .start(sar_start),
    .abort(sar_abort),
    .comp(pins.comp),
    .busy(sar_busy),
    .done(sar_done),
    .trial(sar_trial)
  );

  // analog selector and trial code to the converter
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ADC_MUX_SEL <= lsm_pkg::CH_FIRST;
      ADC_TRIAL_CODE <= 7'h00;
    end else begin
      ADC_MUX_SEL <= ch_q;
      ADC_TRIAL_CODE <= sar_trial;
    end
  end

  // ****************************************
  // result registers and read port
  // ****************************************
  logic [7:0] res_q [lsm_pkg::NUM_CH];
  logic [7:0] pend_q [lsm_pkg::NUM_CH];
  logic [4:0] pend_v_q;
  logic rd_prev_q;
  logic [7:0] rd_addr_q;
  wire rd_start = REG_RD && !rd_prev_q;
  wire rd_busy = REG_RD && rd_prev_q;
  wire tmo_here = win_end && (st_q == ST_CONV) && !sar_done && !short_here && !halt;

  genvar c;
  generate
    for (c = 0; c < lsm_pkg::NUM_CH; c++) begin : g_res
      wire is_ch = (ch_q == 3'(c));
      wire full_ld = (c < lsm_pkg::NUM_STR) ? short_new[c % lsm_pkg::NUM_STR] : 1'b0;
      wire conv_ld = is_ch && sar_done && !halt && !short_here;
      wire tmo_ld = is_ch && tmo_here;
      wire hold = rd_busy && hit(rd_addr_q, lsm_pkg::ADDR_RES_BASE, c);
      wire [7:0] ld_val = full_ld ? lsm_pkg::RES_FULL :
        conv_ld ? {1'b0, sar_trial} :
        (res_q[c] | (8'h01 << lsm_pkg::RES_TMO_BIT));
      wire [7:0] base_val = pend_v_q[c] ? pend_q[c] : res_q[c];
      wire ld = pins.enable && (full_ld || conv_ld || tmo_ld);
      wire [7:0] new_val = full_ld ? lsm_pkg::RES_FULL : conv_ld ? {1'b0, sar_trial} :
        (base_val | (8'h01 << lsm_pkg::RES_TMO_BIT));
      // updates landing during a read wait in a pending slot
      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          res_q[c] <= lsm_pkg::RES_RST;
          pend_q[c] <= lsm_pkg::RES_RST;
          pend_v_q[c] <= 1'b0;
        end else if (ld && hold) begin
          pend_q[c] <= new_val;
          pend_v_q[c] <= 1'b1;
        end else if (ld) begin
          res_q[c] <= (ld_val == new_val) ? ld_val : new_val;
          pend_v_q[c] <= 1'b0;
        end else if (pend_v_q[c] && !hold) begin
          res_q[c] <= pend_q[c];
          pend_v_q[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // read data mux, taken at the start of a read
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    rd_mux = 8'h00;
    for (int k = 0; k < lsm_pkg::NUM_CH; k++) begin
      if (a == lsm_pkg::ADDR_RES_BASE + 8'(k)) rd_mux = res_q[k];
    end
    for (int k = 0; k < lsm_pkg::NUM_STR; k++) begin
      if (a == lsm_pkg::ADDR_IREF_BASE + 8'(k)) rd_mux = {1'b0, iref_q[k]};
    end
    if (a == lsm_pkg::ADDR_VADJ) rd_mux = {1'b0, vadj_q};
    if (a == lsm_pkg::ADDR_FAULT) rd_mux = {3'h0, ov_seen_q, short_q};
    if (a == lsm_pkg::ADDR_STANDBY) rd_mux = {7'h00, standby_q};
  endfunction

  // capture address and data when a read begins
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rd_prev_q <= 1'b0;
      rd_addr_q <= 8'h00;
      REG_RDATA <= 8'h00;
    end else begin
      rd_prev_q <= REG_RD;
      if (rd_start) begin
        rd_addr_q <= REG_ADDR;
        REG_RDATA <= rd_mux(REG_ADDR);
      end
    end
  end

  // current reference codes out
  assign IREF_CODES = '{iref3: iref_q[3], iref2: iref_q[2], iref1: iref_q[1], iref0: iref_q[0]};
  assign VOUT_ADJ = vadj_q;
endmodule

// ### bench/lsm_properties.sv
// concurrent checks on the pins of the led string monitor top
// assumes pins are driven from REF_CLK and reach the logic through two sync flops
`timescale 1ns/1ps
module lsm_properties #(
  parameter int WINDOW_TICKS = lsm_pkg::WINDOW_TICKS
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SYNC_ENABLE,
  input wire logic SUPPLY_UNDERVOLTAGE_LOCKOUT,
  input wire logic DIE_HOT,
  input wire logic OUTPUT_OVERVOLTAGE_SENSE,
  input wire logic [3:0] DRAIN_SHORT_TRIP,
  input wire logic [3:0] STRING_DIM_INPUTS,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic REGULATOR_GATE_EN,
  input wire logic SOFT_START_DISCHARGE,
  input wire logic [3:0] SINK_GATE_DRIVES,
  input wire lsm_pkg::lsm_iref_t IREF_CODES,
  input wire logic [2:0] ADC_MUX_SEL
);
  // ****************************************
  // pin checks, three cycles of pin latency
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  chk_ovp_latch_off: assert property (
    $rose(OUTPUT_OVERVOLTAGE_SENSE) |-> ##3 (!REGULATOR_GATE_EN && SOFT_START_DISCHARGE))
    else $error("overvoltage did not stop switching");
  chk_supply_undervoltage_lockout_all_off: assert property (
    SUPPLY_UNDERVOLTAGE_LOCKOUT [*4] |-> !REGULATOR_GATE_EN && SINK_GATE_DRIVES == 4'h0)
    else $error("outputs active in undervoltage");
  chk_hot_all_off: assert property (
    DIE_HOT [*4] |-> !REGULATOR_GATE_EN && SINK_GATE_DRIVES == 4'h0)
    else $error("outputs active while hot");
  chk_enable_low_off: assert property (
    !SYNC_ENABLE [*4] |-> !REGULATOR_GATE_EN && SINK_GATE_DRIVES == 4'h0)
    else $error("outputs active while disabled");
  chk_sink_dim_gate: assert property (
    (SINK_GATE_DRIVES & ~$past(STRING_DIM_INPUTS, 3)) == 4'h0)
    else $error("sink on outside its dim phase");
  chk_sink_short_off: assert property (
    (SINK_GATE_DRIVES & $past(DRAIN_SHORT_TRIP, 3)) == 4'h0)
    else $error("shorted string sink still on");
  // ****************************************
  // register port checks
  // ****************************************
  chk_rdata_hold: assert property (
    $changed(REG_RDATA) |-> $past(REG_RD) && !$past(REG_RD, 2))
    else $error("read data moved outside a read start");
  chk_unmapped_zero: assert property (
    $rose(REG_RD) && REG_ADDR > 8'h0b |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_iref_write: assert property (
    REG_WR && REG_ADDR == 8'h05 |=> ##1
    {1'b0, IREF_CODES.iref0} == ($past(REG_WDATA, 2) & 8'h7f))
    else $error("current reference code not taken");
  chk_mux_range: assert property (ADC_MUX_SEL <= 3'h4)
    else $error("selector beyond five channels");
endmodule

bind lsm_top lsm_properties #(.WINDOW_TICKS(WINDOW_TICKS)) i_props (
  .REF_CLK(REF_CLK), .RST(RST), .SYNC_ENABLE(SYNC_ENABLE),
  .SUPPLY_UNDERVOLTAGE_LOCKOUT(SUPPLY_UNDERVOLTAGE_LOCKOUT), .DIE_HOT(DIE_HOT),
  .OUTPUT_OVERVOLTAGE_SENSE(OUTPUT_OVERVOLTAGE_SENSE), .DRAIN_SHORT_TRIP(DRAIN_SHORT_TRIP),
  .STRING_DIM_INPUTS(STRING_DIM_INPUTS), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .REGULATOR_GATE_EN(REGULATOR_GATE_EN), .SOFT_START_DISCHARGE(SOFT_START_DISCHARGE),
  .SINK_GATE_DRIVES(SINK_GATE_DRIVES), .IREF_CODES(IREF_CODES), .ADC_MUX_SEL(ADC_MUX_SEL));

// ### bench/lsm_analog_model.sv
// far side model: sar comparator over five channel levels and dimming pwm
// assumes the bench holds levels steady while a channel is measured
`timescale 1ns/1ps
module lsm_analog_model #(
  parameter int PWM_PERIOD = 500,
  parameter int PWM_ON = 250
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [34:0] levels,
  input wire logic [2:0] mux_sel,
  input wire logic [6:0] trial,
  input wire logic [3:0] dim_en,
  output logic comp,
  output logic [3:0] dim
);
  logic [8:0] phase_q;
  logic [6:0] level;
  // comparator: high while the selected level reaches the trial code
  assign level = levels[7*mux_sel +: 7];
  assign comp = (level >= trial);
  // 100 kHz half-duty pwm, ample on-time inside each window
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 9'h000;
      dim <= 4'h0;
    end else begin
      phase_q <= (phase_q == 9'(PWM_PERIOD - 1)) ? 9'h000 : phase_q + 9'h001;
      dim <= dim_en & {4{phase_q < 9'(PWM_ON)}};
    end
  end
endmodule

// ### bench/lsm_top_bench.sv
// self-checking bench of the led string monitor top
// assumes the analog model answers the sar and makes the dimming pwm
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module lsm_top_bench;
  typedef struct packed {logic [7:0] exp; logic [7:0] mask;} lsm_note_t;
  localparam int WIN = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0, supply_undervoltage_lockout = 1'b0, hot = 1'b0, output_overvoltage_sense = 1'b0, wr = 1'b0, rd = 1'b0;
  logic rd_s1 = 1'b0, rd_s2 = 1'b0, gate_en, ss_dis, comp;
  logic [3:0] trip = 4'h0, dim_en = 4'h0, dim, sinks;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [6:0] vadj, trial;
  logic [6:0] lvl [5];
  logic [6:0] code [5];
  logic [2:0] mux;
  lsm_pkg::lsm_iref_t iref;
  lsm_note_t notes[$];
  lsm_note_t nt;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  lsm_top #(.WINDOW_TICKS(WIN)) i_dut (
    .REF_CLK(clk), .RST(rst), .SYNC_ENABLE(en), .SUPPLY_UNDERVOLTAGE_LOCKOUT(supply_undervoltage_lockout),
    .DIE_HOT(hot), .OUTPUT_OVERVOLTAGE_SENSE(output_overvoltage_sense), .ADC_COMP(comp), .DRAIN_SHORT_TRIP(trip),
    .STRING_DIM_INPUTS(dim), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REGULATOR_GATE_EN(gate_en), .SOFT_START_DISCHARGE(ss_dis),
    .SINK_GATE_DRIVES(sinks), .IREF_CODES(iref), .VOUT_ADJ(vadj), .ADC_MUX_SEL(mux),
    .ADC_TRIAL_CODE(trial));

  lsm_analog_model i_analog (.clk(clk), .rst(rst), .dim_en(dim_en), .mux_sel(mux),
    .levels({lvl[4], lvl[3], lvl[2], lvl[1], lvl[0]}), .trial(trial), .comp(comp), .dim(dim));

  // ****************************************
  // tasks
  // ****************************************
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask

  // read note goes in the queue before the byte appears
  task automatic rd_reg(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
    notes.push_back('{e & m, m});
    addr <= a;
    rd <= 1'b1;
    tick(3);
    rd <= 1'b0;
    tick(2);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // monitor: the byte after each read start meets the oldest note; also the hang limit
  always @(posedge clk) begin
    rd_s1 <= rd;
    rd_s2 <= rd_s1;
    cycles <= cycles + 1;
    if (rd_s1 && !rd_s2) begin
      nt = notes.pop_front();
      `CHK("read byte", nt.exp, rdata & nt.mask)
    end
    if (cycles >= 60000) begin
      miscompares++;
      conclude();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hba16));
    foreach (lvl[i]) lvl[i] = 7'($urandom_range(126, 1));
    tick(4);
    rst <= 1'b0;
    tick(1);
    for (int a = 0; a < 12; a++) rd_reg(8'(a), 8'h00);
    rd_reg(8'h3c, 8'h00);
    $display("test reset values done");
    // references and output adjust take random codes; fault record ignores writes
    for (int i = 0; i < 5; i++) begin
      code[i] = 7'($urandom);
      wr_reg(8'h05 + 8'(i), {1'b0, code[i]});
    end
    wr_reg(8'h0a, 8'hff);
    for (int i = 0; i < 5; i++) rd_reg(8'h05 + 8'(i), {1'b0, code[i]});
    rd_reg(8'h0a, 8'h00);
    `CHK("iref codes", {code[3], code[2], code[1], code[0]}, iref)
    `CHK("vout adjust", code[4], vadj)
    $display("test registers done");
    en <= 1'b1;
    dim_en <= 4'hf;
    tick(8000);
    for (int i = 0; i < 5; i++) rd_reg(8'(i), {1'b0, lvl[i]});
    $display("test conversions done");
    // string 1 starved of on-time times out; selector still reaches channel 3
    dim_en <= 4'hd;
    lvl[3] <= 7'($urandom_range(126, 1));
    tick(WIN * 90);
    rd_reg(8'h01, 8'h80, 8'h80);
    rd_reg(8'h03, {1'b0, lvl[3]});
    dim_en <= 4'hf;
    $display("test timeout done");
    trip <= 4'h4;
    tick(10);
    rd_reg(8'h0a, 8'h04);
    rd_reg(8'h02, 8'h7f);
    trip <= 4'h0;
    tick(6000);
    rd_reg(8'h02, 8'h7f);
    `CHK("sink 2 latched off", 1'b0, sinks[2])
    $display("test short done");
    `CHK("gate before", 1'b1, gate_en)
    output_overvoltage_sense <= 1'b1;
    tick(2);
    output_overvoltage_sense <= 1'b0;
    tick(8);
    `CHK("gate latched off", 1'b0, gate_en)
    `CHK("soft start discharge", 1'b1, ss_dis)
    rd_reg(8'h0a, 8'h14);
    wr_reg(8'h0b, 8'h01);
    rd_reg(8'h0b, 8'h01);
    wr_reg(8'h0b, 8'h00);
    tick(6);
    `CHK("gate after standby", 1'b1, gate_en)
    `CHK("soft start released", 1'b0, ss_dis)
    rd_reg(8'h0a, 8'h14);
    $display("test overvoltage done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) supply_undervoltage_lockout <= 1'b1;
      else hot <= 1'b1;
      tick(6);
      `CHK("sinks held", 4'h0, sinks)
      `CHK("gate held", 1'b0, gate_en)
      supply_undervoltage_lockout <= 1'b0;
      hot <= 1'b0;
      tick(6);
      `CHK("gate back", 1'b1, gate_en)
    end
    $display("test lockouts done");
    en <= 1'b0;
    tick(10);
    en <= 1'b1;
    tick(10);
    rd_reg(8'h0a, 8'h00);
    tick(5000);
    rd_reg(8'h02, {1'b0, lvl[2]});
    $display("test enable cycle done");
    conclude();
  end
endmodule
